// ===== rtl/pst_pkg.sv
// package for the program space table access block
// assumes one core clock, async active-low reset, core issues one table op at a time
//
// How it works
// - each program location holds 24 bits: a lower 16-bit word and an upper word whose top byte is unimplemented.
// - the lower and upper words share one even address; the op picks the word, and address bit 0 only picks a byte.
// - the program counter steps by two per 24-bit word so program and data word addresses line up.
// - program addresses 0x000000 up to 0x0001ff, below 0x000200, are kept for fixed vectors, not ordinary code.
// - after reset execution starts at 0x000000, where the image holds an absolute jump whose target is at 0x000002.
// - a word-mode table read low copies program bits 15..0 into the whole data word.
// - a byte-mode table read low returns the high byte of the low word when byte select is one, else the low byte.
// - a word-mode table read high returns program bits 23..16 in the low byte and zero in the high byte.
// - a byte-mode table read high returns the selected upper-word byte in bits 7..0, zero for the phantom byte.
// - only table read high and table write high reach the top 8 program bits as data.
// - every table op forms its program address from the table page selector and the offset.
// - table page selector bit 7 low selects user space, high selects configuration space.
package pst_pkg;
    localparam int          PW_BITS       = 24;
    localparam int          DW_BITS       = 16;
    localparam int          PA_BITS       = 24;
    localparam int          PAGE_BITS     = 8;
    localparam int          CFG_BIT       = 7;
    localparam logic [23:0] RESET_VECTOR  = 24'h000000;
    localparam logic [23:0] VECTOR_END    = 24'h000200;
    localparam logic [23:0] PC_STEP       = 24'h000002;
    localparam logic [15:0] PHANTOM_ZERO  = 16'h0000;

    typedef enum logic [1:0] {
        PST_OP_READ_LOW,
        PST_OP_READ_HIGH,
        PST_OP_WRITE_LOW,
        PST_OP_WRITE_HIGH
    } pst_op_e;

    typedef struct packed {
        pst_op_e     op;
        logic        byte_mode;
        logic [7:0]  page;
        logic [15:0] offset;
        logic [15:0] wdata;
    } pst_req_s;

    typedef struct packed {
        logic        cfg_space;
        logic [22:0] word_addr;
    } pst_addr_s;
endpackage

// ===== rtl/pst_word_mem.sv
// small program word store standing in for the flash array
// assumes reads and writes are single-cycle; read data comes out of a register
module pst_word_mem #(
    parameter int AW = 8
) (
    input  wire logic          clk,
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [23:0]   rd_data,
    input  wire logic          wr_lo,
    input  wire logic          wr_hi,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [23:0]   wr_data
);
    logic [23:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (wr_lo) begin
            mem[wr_addr][15:0] <= wr_data[15:0];
        end
        if (wr_hi) begin
            mem[wr_addr][23:16] <= wr_data[23:16];
        end
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// ===== rtl/pst_table_access.sv
// table access path between the core and program space, plus fetch address counter
// assumes the core holds req stable while req_valid and waits for rsp_valid
module pst_table_access #(
    parameter int AW = 8
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire pst_pkg::pst_req_s req,
    output logic                   rsp_valid,
    output logic [15:0]            rsp_data,
    output logic                   rsp_cfg_space,
    output logic                   rsp_vector_area,
    input  wire logic              fetch_step,
    output logic [23:0]            pc,
    output logic                   pc_in_vectors
);
    typedef enum logic [1:0] {PST_IDLE, PST_READ, PST_DONE} pst_state_e;

    pst_state_e          state_r, state_nxt;
    pst_pkg::pst_req_s   req_r;
    pst_pkg::pst_addr_s  addr_w;
    logic [23:0]         pc_r;
    logic [23:0]         full_addr_w;
    logic [23:0]         rd_word_w;
    logic [23:0]         wr_word_w;
    logic [15:0]         data_nxt;
    logic [15:0]         data_r;
    logic                rsp_cfg_r;
    logic                rsp_vec_r;
    logic                byte_sel_w;
    logic                is_read_w;
    logic                accept_w;
    logic                wr_lo_w;
    logic                wr_hi_w;
    logic                mem_pick_w;
    logic                rd_en_w;
    logic [AW-1:0]       mem_addr_w;

    assign accept_w   = req_valid && (state_r == PST_IDLE);
    assign req_ready  = (state_r == PST_IDLE);
    assign is_read_w  = (req.op == pst_pkg::PST_OP_READ_LOW) || (req.op == pst_pkg::PST_OP_READ_HIGH);

    // page and offset together name the program word; offset bit 0 only picks a byte
    assign full_addr_w          = {req.page, req.offset};
    assign addr_w               = '{cfg_space: req.page[pst_pkg::CFG_BIT],
                                    word_addr: full_addr_w[23:1]};
    assign byte_sel_w           = req_r.offset[0];

    // only the write-high op may touch bits 23..16
    assign wr_lo_w   = accept_w && (req.op == pst_pkg::PST_OP_WRITE_LOW);
    assign wr_hi_w   = accept_w && (req.op == pst_pkg::PST_OP_WRITE_HIGH);
    assign wr_word_w = {req.wdata[7:0], req.wdata};
    assign mem_pick_w = addr_w.cfg_space;
    // the small store keeps user and configuration words apart by its top index bit;
    // upper page and offset bits alias onto it, a limitation of the reduced model
    assign rd_en_w    = accept_w && is_read_w;
    assign mem_addr_w = {mem_pick_w, addr_w.word_addr[AW-2:0]};

    pst_word_mem #(.AW(AW)) u_mem (
        .clk     (clk),
        .rd_en   (rd_en_w),
        .rd_addr (mem_addr_w),
        .rd_data (rd_word_w),
        .wr_lo   (wr_lo_w),
        .wr_hi   (wr_hi_w),
        .wr_addr (mem_addr_w),
        .wr_data (wr_word_w)
    );

    // byte lane selection; the top byte of the upper word never exists
    always_comb begin
        data_nxt = pst_pkg::PHANTOM_ZERO;
        if (req_r.op == pst_pkg::PST_OP_READ_LOW) begin
            if (!req_r.byte_mode) begin
                data_nxt = rd_word_w[15:0];
            end else if (byte_sel_w) begin
                data_nxt = {8'h00, rd_word_w[15:8]};
            end else begin
                data_nxt = {8'h00, rd_word_w[7:0]};
            end
        end else begin
            if (!req_r.byte_mode) begin
                data_nxt = {8'h00, rd_word_w[23:16]};
            end else if (!byte_sel_w) begin
                data_nxt = {8'h00, rd_word_w[23:16]};
            end
        end
    end

    // a read needs one extra cycle because the store answers from a register
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            PST_IDLE: begin
                if (req_valid) begin
                    state_nxt = is_read_w ? PST_READ : PST_DONE;
                end
            end
            PST_READ: state_nxt = PST_DONE;
            PST_DONE: state_nxt = PST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r   <= PST_IDLE;
            req_r     <= '0;
            data_r    <= 16'h0000;
            rsp_cfg_r <= 1'b0;
            rsp_vec_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (accept_w) begin
                req_r     <= req;
                rsp_cfg_r <= addr_w.cfg_space;
                rsp_vec_r <= !addr_w.cfg_space && (full_addr_w < pst_pkg::VECTOR_END);
            end
            if (state_r == PST_READ) begin
                data_r <= data_nxt;
            end else if (accept_w) begin
                data_r <= 16'h0000;
            end
        end
    end

    // fetch counter: starts at the reset vector, two per instruction word
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pc_r <= pst_pkg::RESET_VECTOR;
        end else if (fetch_step) begin
            pc_r <= pc_r + pst_pkg::PC_STEP;
        end
    end

    assign pc              = pc_r;
    assign pc_in_vectors   = pc_r < pst_pkg::VECTOR_END;
    assign rsp_valid       = (state_r == PST_DONE);
    assign rsp_data        = data_r;
    assign rsp_cfg_space   = rsp_cfg_r;
    assign rsp_vector_area = rsp_vec_r;

    // a read walks taken, store access, answer, idle; a write has no store access step
    sequence s_read_taken;
        accept_w && is_read_w;
    endsequence

    sequence s_write_taken;
        accept_w && !is_read_w;
    endsequence

    sequence s_read_answer;
        (!req_ready && !rsp_valid) ##1 (!req_ready && rsp_valid) ##1 (req_ready && !rsp_valid);
    endsequence

    sequence s_write_answer;
        (!req_ready && rsp_valid) ##1 (req_ready && !rsp_valid);
    endsequence

    a_pc_reset_start: assert property (@(posedge clk)
        $rose(nrst) |-> pc_r == pst_pkg::RESET_VECTOR)
        else $error("pc not at reset vector after reset");

    a_pc_step_two: assert property (@(posedge clk) disable iff (!nrst)
        fetch_step |=> pc_r == $past(pc_r) + pst_pkg::PC_STEP)
        else $error("pc did not advance by two");

    a_pc_hold: assert property (@(posedge clk) disable iff (!nrst)
        !fetch_step |=> $stable(pc_r))
        else $error("pc moved without a fetch step");

    a_read_latency: assert property (@(posedge clk) disable iff (!nrst)
        s_read_taken |=> ##1 rsp_valid)
        else $error("read answer not two cycles after request");

    a_read_handshake: assert property (@(posedge clk) disable iff (!nrst)
        s_read_taken |=> s_read_answer)
        else $error("read handshake out of order");

    a_write_handshake: assert property (@(posedge clk) disable iff (!nrst)
        s_write_taken |=> s_write_answer)
        else $error("write handshake out of order");

    a_write_no_data: assert property (@(posedge clk) disable iff (!nrst)
        s_write_taken |=> rsp_data == 16'h0000)
        else $error("write exposed program data");

    a_word_low: assert property (@(posedge clk) disable iff (!nrst)
        (state_r == PST_READ && req_r.op == pst_pkg::PST_OP_READ_LOW && !req_r.byte_mode)
        |=> rsp_data == $past(rd_word_w[15:0]))
        else $error("word read low wrong");

    a_byte_low: assert property (@(posedge clk) disable iff (!nrst)
        (state_r == PST_READ && req_r.op == pst_pkg::PST_OP_READ_LOW && req_r.byte_mode)
        |=> rsp_data[15:8] == 8'h00 && rsp_data[7:0] == ($past(byte_sel_w) ? $past(rd_word_w[15:8])
                                                                             : $past(rd_word_w[7:0])))
        else $error("byte read low wrong");

    a_word_high: assert property (@(posedge clk) disable iff (!nrst)
        (state_r == PST_READ && req_r.op == pst_pkg::PST_OP_READ_HIGH && !req_r.byte_mode)
        |=> rsp_data == {8'h00, $past(rd_word_w[23:16])})
        else $error("word read high wrong");

    a_byte_high: assert property (@(posedge clk) disable iff (!nrst)
        (state_r == PST_READ && req_r.op == pst_pkg::PST_OP_READ_HIGH && req_r.byte_mode && !byte_sel_w)
        |=> rsp_data == {8'h00, $past(rd_word_w[23:16])})
        else $error("byte read high wrong");

    a_phantom_zero: assert property (@(posedge clk) disable iff (!nrst)
        (state_r == PST_READ && req_r.op == pst_pkg::PST_OP_READ_HIGH && req_r.byte_mode && byte_sel_w)
        |=> rsp_data == 16'h0000)
        else $error("phantom byte not zero");

    a_top_byte_write: assert property (@(posedge clk) disable iff (!nrst)
        wr_hi_w |-> req.op == pst_pkg::PST_OP_WRITE_HIGH && !wr_lo_w)
        else $error("top byte written by wrong op");

    a_cfg_select: assert property (@(posedge clk) disable iff (!nrst)
        accept_w |=> rsp_cfg_space == $past(req.page[pst_pkg::CFG_BIT]))
        else $error("space select not from page bit 7");

    a_vector_flag: assert property (@(posedge clk) disable iff (!nrst)
        accept_w |=> rsp_vector_area == (!$past(req.page[pst_pkg::CFG_BIT])
                                         && $past({req.page, req.offset}) < pst_pkg::VECTOR_END))
        else $error("vector area flag wrong");
endmodule

// ===== verification/pst_core_model.sv
// core-side model: issues one table op at a time and waits for its answer
// assumes a free-running clk; every drive happens on a falling edge
module pst_core_model (
    input  wire logic         clk,
    input  wire logic         req_ready,
    input  wire logic         rsp_valid,
    output logic              req_valid,
    output pst_pkg::pst_req_s req
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        req_valid = 1'b0;
        req       = '0;
    end
    // lat counts falling edges from the taking edge to the answer, -1 if none came
    // wt counts falling edges spent waiting for ready before the request was taken
    task automatic do_op(input logic [1:0] op, input logic bm, input logic [7:0] pg, input logic [15:0] off,
                         input logic [15:0] wd, output int lat, output int wt);
        int n;
        n = 0;
        @(negedge clk);
        req_valid = 1'b1;
        req = '{pst_pkg::pst_op_e'(op), bm, pg, off, wd};
        while (req_ready !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        wt = n;
        @(posedge clk);
        @(negedge clk);
        req_valid = 1'b0;
        // scramble the released fields so a stale offset cannot pass for the taken one
        req.offset = ~off;
        req.wdata  = ~wd;
        lat = 0;
        while (rsp_valid !== 1'b1 && lat < 20) begin
            @(negedge clk);
            lat++;
        end
        if (rsp_valid !== 1'b1) lat = -1;
    endtask
endmodule

// ===== verification/pst_table_access_test.sv
// self-checking bench for the table access block with a shadow copy of program words
// assumes the core model drives requests; inputs change on falling edges only
module pst_table_access_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic fetch_step = 1'b0;
    logic req_valid, req_ready, rsp_valid, rsp_cfg_space, rsp_vector_area, pc_in_vectors;
    pst_pkg::pst_req_s req;
    logic [15:0] rsp_data;
    logic [23:0] pc;
    logic [23:0] shadow [256];
    int err_total = 0;
    int comparisons = 0;
    always #10 clk = ~clk;
    pst_table_access #(.AW(8)) i_pst_table_access (.clk(clk), .nrst(nrst), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_cfg_space(rsp_cfg_space), .rsp_vector_area(rsp_vector_area), .fetch_step(fetch_step),
        .pc(pc), .pc_in_vectors(pc_in_vectors));
    pst_core_model i_pst_core_model (.clk(clk), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .req_valid(req_valid), .req(req));
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ops 0/1 are reads (low/high), 2/3 writes (low/high)
    function automatic logic [15:0] exp_read(input logic [1:0] o, input logic bm, input logic bs, input logic [23:0] w);
        if (!o[0]) return bm ? {8'h00, bs ? w[15:8] : w[7:0]} : w[15:0];
        return (bm && bs) ? 16'h0000 : {8'h00, w[23:16]};
    endfunction
    // page bits other than the space bit alias onto the same small store
    task automatic pick(input logic [7:0] i, output logic [7:0] pg, output logic [15:0] off);
        pg  = {i[7], ($urandom % 2) ? 7'h00 : 7'($urandom)};
        off = {($urandom % 2) ? 8'h00 : 8'($urandom), i[6:0], 1'($urandom)};
    endtask
    task automatic op(input logic [1:0] o, input logic bm, input logic [7:0] pg, input logic [15:0] off,
                      input logic [15:0] wd, input logic [7:0] i);
        int lat;
        int wt;
        i_pst_core_model.do_op(o, bm, pg, off, wd, lat, wt);
        chk(24'(wt), 24'h000000);
        chk(24'(lat), o[1] ? 24'h000000 : 24'h000001);
        chk(24'(rsp_cfg_space), 24'(pg[7]));
        chk(24'(rsp_vector_area), 24'(!pg[7] && {pg, off} < 24'h000200));
        if (o[1]) begin
            chk(24'(rsp_data), 24'h000000);
            if (o[0]) shadow[i][23:16] = wd[7:0];
            else shadow[i][15:0] = wd;
        end else begin
            chk(24'(rsp_data), 24'(exp_read(o, bm, off[0], shadow[i])));
        end
    endtask
    initial begin
        logic [7:0] pg;
        logic [15:0] off;
        logic [23:0] w;
        logic [7:0] i;
        void'($urandom(74126));
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        chk(pc, 24'h000000);
        chk(24'(pc_in_vectors), 24'h000001);
        w = 24'h000000;
        for (int k = 0; k < 300; k++) begin
            fetch_step = (k < 256) ? 1'b1 : 1'($urandom);
            @(negedge clk);
            if (fetch_step) w = w + 24'h000002;
            chk(pc, w);
            chk(24'(pc_in_vectors), 24'(w < 24'h000200));
        end
        fetch_step = 1'b0;
        nrst = 1'b0;
        @(negedge clk);
        chk(pc, 24'h000000);
        nrst = 1'b1;
        for (int k = 0; k < 256; k++) begin
            i = 8'(k);
            pick(i, pg, off);
            op(2'd3, 1'b0, pg, off, 16'($urandom), i);
            pick(i, pg, off);
            op(2'd2, 1'b0, pg, off, 16'($urandom), i);
        end
        // corner: last vector word 0x0001fe and first code word 0x000200, every read mode
        for (int k = 0; k < 16; k++) begin
            off = k[3] ? {15'h0100, k[0]} : {15'h00ff, k[0]};
            op({1'b0, k[1]}, k[2], 8'h00, off, 16'h0000, {1'b0, off[7:1]});
        end
        for (int k = 0; k < 400; k++) begin
            i = 8'($urandom);
            pick(i, pg, off);
            op(2'($urandom), 1'($urandom), pg, off, 16'($urandom), i);
        end
        close_out();
    end
    initial begin
        repeat (30000) @(posedge clk);
        err_total++;
        close_out();
    end
endmodule
